// file: logic/isc_start_gen.sv
// start-condition generator with bus collision detection
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - start requested with data or clock line low raises a collision
// - clock line low before we pull data low is a collision
// - on collision abort start, set flag, send port back to idle
// - start begins with both lines released; both watched until data is pulled low
// - data line high: load counter from reload bits 6:0, count to zero
// - data low during first count: reset counter, pull data low at once
// - data high through first count: pull data low when count ends
// - after data low reload and count again; clock low is no collision
// - pull clock line low when second count ends, start complete
// - two masters starting together are not flagged; they arbitrate later
// - one serial clock period equals two full counter rollovers
// - counter steps down on second and fourth phase of each cycle
// - counter stops at zero until reloaded
module isc_start_gen
   import isc_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_START,
   input wire logic I_NEXT_PHASE,
   input wire logic I_COLL_CLR,
   input wire logic [RATE_W-1:0] I_RELOAD,
   input wire logic I_SDA,
   input wire logic I_SCL,
   output logic O_SDA,
   output logic O_SDA_OE_N,
   output logic O_SCL,
   output logic O_SCL_OE_N,
   output logic O_BUS_COLLISION_FLAG,
   output logic O_START_DONE,
   output logic O_BUSY,
   output logic O_PORT_RESET
);

   localparam isc_seq_t SEQ_RST = '{
      state: ST_IDLE,
      phase: PH_RST,
      sda_meta: 1'b1,
      sda_sync: 1'b1,
      scl_meta: 1'b1,
      scl_sync: 1'b1,
      sda_rel: 1'b1,
      scl_rel: 1'b1,
      drv_lvl: 1'b0,
      coll_flag: 1'b0,
      done: 1'b0,
      busy: 1'b0,
      port_rst: 1'b0
   };

   isc_seq_t st_r;
   isc_seq_t st_nxt;
   logic cnt_load;
   logic cnt_tick;
   logic cnt_zero;
   logic [RATE_W-1:0] cnt_value;
   logic sda_hi;
   logic scl_hi;
   logic coll_set;

   // synchronised line levels, read only from the second stage
   assign sda_hi = st_r.sda_sync;
   assign scl_hi = st_r.scl_sync;
   assign cnt_tick = is_tick(st_r.phase);

   // shared rate counter
   isc_rate_counter u_rate
   (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_load(cnt_load),
      .i_tick(cnt_tick),
      .i_reload(I_RELOAD),
      .o_count(cnt_value),
      .o_zero(cnt_zero)
   );

   // sequencer next state
   always_comb
   begin
      st_nxt = st_r;
      cnt_load = 1'b0;
      coll_set = 1'b0;
      st_nxt.phase = st_r.phase + PH_ONE;
      st_nxt.sda_meta = I_SDA;
      st_nxt.sda_sync = st_r.sda_meta;
      st_nxt.scl_meta = I_SCL;
      st_nxt.scl_sync = st_r.scl_meta;
      st_nxt.drv_lvl = 1'b0;
      st_nxt.done = 1'b0;
      st_nxt.port_rst = 1'b0;
      case (st_r.state)
         ST_IDLE:
         begin
            // lines released while idle
            st_nxt.sda_rel = 1'b1;
            st_nxt.scl_rel = 1'b1;
            if (I_START)
            begin
               st_nxt.state = ST_CHECK;
            end
         end
         ST_CHECK:
         begin
            if (!sda_hi || !scl_hi)
            begin
               coll_set = 1'b1;
            end
            else
            begin
               cnt_load = 1'b1;
               st_nxt.state = ST_FIRST;
            end
         end
         ST_FIRST:
         begin
            if (!scl_hi)
            begin
               coll_set = 1'b1;
            end
            else if (!sda_hi)
            begin
               // another master started first: no collision
               cnt_load = 1'b1;
               st_nxt.sda_rel = 1'b0;
               st_nxt.state = ST_SECOND;
            end
            else if (cnt_zero)
            begin
               cnt_load = 1'b1;
               st_nxt.sda_rel = 1'b0;
               st_nxt.state = ST_SECOND;
            end
         end
         ST_SECOND:
         begin
            // clock line level is ignored here
            if (cnt_zero)
            begin
               // one count per half period: two rollovers per period
               st_nxt.scl_rel = 1'b0;
               st_nxt.done = 1'b1;
               st_nxt.state = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            // lines held low until the address phase takes over
            if (I_NEXT_PHASE)
            begin
               st_nxt.sda_rel = 1'b1;
               st_nxt.scl_rel = 1'b1;
               st_nxt.state = ST_IDLE;
            end
         end
         default:
         begin
            st_nxt.state = ST_IDLE;
            st_nxt.sda_rel = 1'b1;
            st_nxt.scl_rel = 1'b1;
         end
      endcase
      // collision: release both lines and return the port to idle
      if (coll_set)
      begin
         st_nxt.state = ST_IDLE;
         st_nxt.sda_rel = 1'b1;
         st_nxt.scl_rel = 1'b1;
         st_nxt.port_rst = 1'b1;
      end
      // sticky flag, a new collision wins over the clear
      if (coll_set)
      begin
         st_nxt.coll_flag = 1'b1;
      end
      else if (I_COLL_CLR)
      begin
         st_nxt.coll_flag = 1'b0;
      end
      st_nxt.busy = (st_nxt.state != ST_IDLE);
   end

   // state register
   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         st_r <= SEQ_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign O_SDA = st_r.drv_lvl;
   assign O_SDA_OE_N = st_r.sda_rel;
   assign O_SCL = st_r.drv_lvl;
   assign O_SCL_OE_N = st_r.scl_rel;
   assign O_BUS_COLLISION_FLAG = st_r.coll_flag;
   assign O_START_DONE = st_r.done;
   assign O_BUSY = st_r.busy;
   assign O_PORT_RESET = st_r.port_rst;

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);

   // a request from idle starts with both lines released
   a_start_lines_free:
      assert property (st_r.state == ST_IDLE && I_START
                       |=> st_r.state == ST_CHECK && O_SDA_OE_N
                           && O_SCL_OE_N)
      else $error("start did not begin with both lines released");

   // a low line at the beginning aborts with the flag
   a_begin_low_coll:
      assert property (st_r.state == ST_CHECK && !(sda_hi && scl_hi)
                       |=> O_BUS_COLLISION_FLAG && O_PORT_RESET
                           && st_r.state == ST_IDLE)
      else $error("low line at start did not raise a collision");

   // clock low during the first count is a collision
   a_first_scl_coll:
      assert property (st_r.state == ST_FIRST && !scl_hi
                       |=> O_BUS_COLLISION_FLAG && O_SDA_OE_N
                           && O_SCL_OE_N)
      else $error("clock low in first count not flagged");

   // collision leaves the port idle and the lines released
   a_abort_to_idle:
      assert property (O_PORT_RESET
                       |-> st_r.state == ST_IDLE && O_SDA_OE_N
                           && O_SCL_OE_N && O_BUS_COLLISION_FLAG)
      else $error("collision did not return the port to idle");

   // data low by another master pulls ours low at once
   a_early_data_low:
      assert property (st_r.state == ST_FIRST && scl_hi && !sda_hi
                       |=> !O_SDA_OE_N && st_r.state == ST_SECOND
                           && !O_PORT_RESET
                           && O_BUS_COLLISION_FLAG
                              == ($past(O_BUS_COLLISION_FLAG)
                                  && !$past(I_COLL_CLR)))
      else $error("data line not asserted early");

   // data pulled low only when the first count ends
   a_data_at_end:
      assert property (st_r.state == ST_FIRST && scl_hi && sda_hi
                       |=> O_SDA_OE_N == !$past(cnt_zero))
      else $error("data line asserted at the wrong time");

   // no collision is raised in the second count
   a_second_no_coll:
      assert property (st_r.state == ST_SECOND && !O_BUS_COLLISION_FLAG
                       |=> !O_BUS_COLLISION_FLAG)
      else $error("collision raised in second count");

   // clock pulled low as the second count ends
   a_clock_at_end:
      assert property (st_r.state == ST_SECOND && cnt_zero
                       |=> !O_SCL_OE_N && O_START_DONE ##1 !O_START_DONE)
      else $error("clock line not asserted at end of count");

   // flag sticky until cleared
   a_flag_sticky:
      assert property (O_BUS_COLLISION_FLAG && !I_COLL_CLR
                       |=> O_BUS_COLLISION_FLAG)
      else $error("collision flag dropped without a clear");

   // a collision in the same cycle as a clear keeps the flag
   a_set_beats_clear:
      assert property (coll_set && I_COLL_CLR |=> O_BUS_COLLISION_FLAG)
      else $error("clear won over a new collision");

   // ticks fall on every second clock
   a_tick_spacing:
      assert property (cnt_tick |=> !cnt_tick ##1 cnt_tick)
      else $error("counter tick spacing wrong");

   // lines are never driven high
   a_only_pull_low:
      assert property (!O_SDA && !O_SCL)
      else $error("a bus line was driven high");

   c_start_done:
      cover property (st_r.state == ST_SECOND && cnt_zero);
   c_begin_coll:
      cover property (st_r.state == ST_CHECK && !sda_hi);
   c_scl_coll:
      cover property (st_r.state == ST_FIRST && !scl_hi);
   c_early_data:
      cover property (st_r.state == ST_FIRST && scl_hi && !sda_hi);
   c_set_wins:
      cover property (coll_set && I_COLL_CLR);

endmodule // isc_start_gen
`default_nettype wire

// file: common/isc_pkg.sv
// package: constants and types of the start/collision generator
`default_nettype none
package isc_pkg;

   // rate counter width and the reload field taken from the reload value
   localparam int RATE_W = 7;
   localparam logic [RATE_W-1:0] RATE_RST = 7'h00;
   localparam logic [RATE_W-1:0] RATE_ZERO = 7'h00;
   localparam logic [RATE_W-1:0] RATE_ONE = 7'h01;

   // four internal phases per instruction cycle, counter steps on two
   localparam int PH_W = 2;
   localparam logic [PH_W-1:0] PH_RST = 2'h0;
   localparam logic [PH_W-1:0] PH_ONE = 2'h1;
   localparam logic [PH_W-1:0] PH_SECOND = 2'h1;
   localparam logic [PH_W-1:0] PH_FOURTH = 2'h3;

   // rollovers per serial clock period, and the worked example
   localparam int ROLLOVERS_PER_SCL = 2;
   localparam logic [RATE_W-1:0] EXAMPLE_RELOAD = 7'h19;
   localparam int EXAMPLE_INSN_HZ = 10_000_000;
   localparam int EXAMPLE_SCL_HZ = 400_000;

   // bus clock of this implementation
   localparam int CLK_PERIOD_NS = 25;

   // start sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE   = 5'b0_0001,
      ST_CHECK  = 5'b0_0010,
      ST_FIRST  = 5'b0_0100,
      ST_SECOND = 5'b0_1000,
      ST_HOLD   = 5'b1_0000
   } isc_state_t;

   // state of the rate counter module
   typedef struct packed {
      logic [RATE_W-1:0] count;
   } isc_cnt_t;

   // state of the sequencer
   typedef struct packed {
      isc_state_t state;
      logic [PH_W-1:0] phase;
      logic sda_meta;
      logic sda_sync;
      logic scl_meta;
      logic scl_sync;
      logic sda_rel;
      logic scl_rel;
      logic drv_lvl;
      logic coll_flag;
      logic done;
      logic busy;
      logic port_rst;
   } isc_seq_t;

   // true on the second and fourth phase of an instruction cycle
   function automatic logic is_tick(input logic [PH_W-1:0] ph);
      is_tick = (ph == PH_SECOND) || (ph == PH_FOURTH);
   endfunction

endpackage
`default_nettype wire

// file: logic/isc_rate_counter.sv
// rate counter: reload, count down on ticks, stop at zero
`timescale 1ns/1ps
`default_nettype none
module isc_rate_counter
   import isc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic i_tick,
   input wire logic [RATE_W-1:0] i_reload,
   output logic [RATE_W-1:0] o_count,
   output logic o_zero
);

   localparam isc_cnt_t CNT_RST = '{count: RATE_RST};

   isc_cnt_t cnt_r;
   isc_cnt_t cnt_nxt;

   // load wins, otherwise step down on a tick until zero
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (i_load)
      begin
         cnt_nxt.count = i_reload;
      end
      else if (i_tick && (cnt_r.count != RATE_ZERO))
      begin
         cnt_nxt.count = cnt_r.count - RATE_ONE;
      end
   end

   // state register
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_r <= CNT_RST;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   assign o_count = cnt_r.count;
   assign o_zero = (cnt_r.count == RATE_ZERO);

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   // a stopped counter stays at zero until reloaded
   a_zero_stays_stopped:
      assert property (o_zero && !i_load |=> o_zero)
      else $error("rate counter left zero without a reload");

   // one step down per tick
   a_tick_steps_down:
      assert property (i_tick && !i_load && !o_zero
                       |=> o_count == $past(o_count) - RATE_ONE)
      else $error("rate counter did not step down on a tick");

   // a load takes the reload value
   a_load_takes_value:
      assert property (i_load |=> o_count == $past(i_reload))
      else $error("rate counter did not take the reload value");

endmodule // isc_rate_counter
`default_nettype wire

// file: dv/isc_bus_partner.sv
// bus partner: pull-ups and another master on both lines
`timescale 1ns/1ps
`default_nettype none
module isc_bus_partner
(
   input wire logic i_sda_oe_n,
   input wire logic i_sda,
   input wire logic i_scl_oe_n,
   input wire logic i_scl,
   input wire logic i_pull_sda,
   input wire logic i_pull_scl,
   input wire logic i_run_clk,
   output logic o_sda_wire,
   output logic o_scl_wire
);
   logic clk_low = 1'h0;
   // other master clock, 200 ns, off phase, still outside frames
   initial
   begin
      #37;
      forever
      begin
         #100;
         clk_low = i_run_clk ? !clk_low : 1'h0;
      end
   end
   // wired-and, released lines float high on pull-ups
   assign o_sda_wire = !(!i_sda_oe_n && !i_sda)
                       && !i_pull_sda;
   assign o_scl_wire = !(!i_scl_oe_n && !i_scl)
                       && !i_pull_scl && !clk_low;
endmodule // isc_bus_partner
`default_nettype wire

// file: dv/isc_start_gen_bench.sv
// bench: start generation and collisions against a bus partner
`timescale 1ns/1ps
`default_nettype none
module isc_start_gen_bench
   import isc_pkg::*;
;
   logic clk = 1'h0, rst = 1'h1, start = 1'h0, nxt = 1'h0, clr = 1'h0;
   logic [RATE_W-1:0] reload = 7'h00;
   logic p_sda = 1'h0, p_scl = 1'h0, p_run = 1'h0;
   logic sda_w, scl_w, sda_o, sda_oe_n, scl_o, scl_oe_n;
   logic flag, done, busy, prst;
   int n_fail = 0, checks = 0;
   // design and far side
   isc_start_gen dut (.I_CLK(clk), .I_RST(rst), .I_START(start),
      .I_NEXT_PHASE(nxt), .I_COLL_CLR(clr), .I_RELOAD(reload),
      .I_SDA(sda_w), .I_SCL(scl_w), .O_SDA(sda_o), .O_SDA_OE_N(sda_oe_n),
      .O_SCL(scl_o), .O_SCL_OE_N(scl_oe_n), .O_BUS_COLLISION_FLAG(flag),
      .O_START_DONE(done), .O_BUSY(busy), .O_PORT_RESET(prst));
   isc_bus_partner partner (.i_sda_oe_n(sda_oe_n), .i_sda(sda_o),
      .i_scl_oe_n(scl_oe_n), .i_scl(scl_o), .i_pull_sda(p_sda),
      .i_pull_scl(p_scl), .i_run_clk(p_run), .o_sda_wire(sda_w),
      .o_scl_wire(scl_w));
   // 40 mhz clock
   initial
   begin
      forever
      begin
         #12.5;
         clk = !clk;
      end
   end
   task automatic final_report();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return sda_oe_n;
         1: return scl_oe_n;
         default: return flag;
      endcase
   endfunction
   // bounded wait on an output, n counts falling edges
   task automatic wait_sig(input int s, input logic v, input int lim,
      output int n);
      n = 0;
      while (sig(s) !== v && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      if (sig(s) !== v)
      begin
         n_fail++;
         $display("wrong value wait %0d expected %h seen %h", s, v, sig(s));
         final_report();
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      @(negedge clk);
      s = 1'h0;
   endtask
   // outputs while reset is held
   task automatic t_reset();
      check("sda_oe_n", sda_oe_n, 1);
      check("scl_oe_n", scl_oe_n, 1);
      check("flag", flag, 0);
      check("busy", busy, 0);
      check("done", done, 0);
      check("port reset", prst, 0);
      $display("test reset done");
   endtask
   // clean start, both counts timed
   task automatic t_normal(input logic [RATE_W-1:0] r);
      int n;
      logic ok;
      reload = r;
      pulse(start);
      check("busy", busy, 1);
      pulse(nxt);
      check("busy ignore", busy, 1);
      wait_sig(0, 0, 400, n);
      // r ticks two clocks apart, plus load and sampling slack
      ok = (n + 2 >= 2 * r + 1) && (n + 2 <= 2 * r + 5);
      check("first count", ok, 1);
      check("sda_o", sda_o, 0);
      check("scl before sda", scl_oe_n, 1);
      wait_sig(1, 0, 400, n);
      ok = (n >= 2 * r) && (n <= 2 * r + 2);
      check("second count", ok, 1);
      check("scl_o", scl_o, 0);
      check("done", done, 1);
      check("flag", flag, 0);
      cyc(1);
      check("done pulse", done, 0);
      cyc(2);
      check("sda held", sda_oe_n, 0);
      pulse(nxt);
      cyc(1);
      check("sda free", sda_oe_n, 1);
      check("scl free", scl_oe_n, 1);
      check("idle", busy, 0);
      $display("test start reload %h done", r);
   endtask
   // line already low when the start begins
   task automatic t_begin(input int which);
      int n;
      p_sda = (which == 0);
      p_scl = (which != 0);
      cyc(4);
      // second pass holds the clear across the collision edge
      clr = (which != 0);
      pulse(start);
      wait_sig(2, 1, 6, n);
      clr = 1'h0;
      check("set wins", flag, 1);
      check("port reset", prst, 1);
      check("busy", busy, 0);
      check("sda_oe_n", sda_oe_n, 1);
      check("scl_oe_n", scl_oe_n, 1);
      cyc(1);
      check("port reset pulse", prst, 0);
      cyc(4);
      check("flag sticky", flag, 1);
      p_sda = 1'h0;
      p_scl = 1'h0;
      cyc(3);
      pulse(clr);
      check("flag clear", flag, 0);
      $display("test begin collision %0d done", which);
   endtask
   // clock line toggled by another master in the first count
   task automatic t_scl_first();
      int n;
      reload = 7'h19;
      pulse(start);
      cyc(6);
      p_run = 1'h1;
      wait_sig(2, 1, 40, n);
      check("port reset", prst, 1);
      check("sda_oe_n", sda_oe_n, 1);
      check("scl_oe_n", scl_oe_n, 1);
      check("busy", busy, 0);
      p_run = 1'h0;
      cyc(12);
      pulse(clr);
      check("flag clear", flag, 0);
      $display("test clock collision done");
      t_normal(7'h03);
   endtask
   // other master pulls data first, clock dips in second count
   task automatic t_early();
      int n;
      reload = 7'h19;
      pulse(start);
      cyc(6);
      p_sda = 1'h1;
      wait_sig(0, 0, 8, n);
      check("early flag", flag, 0);
      check("early scl", scl_oe_n, 1);
      cyc(10);
      p_scl = 1'h1;
      cyc(4);
      p_scl = 1'h0;
      wait_sig(1, 0, 80, n);
      check("second flag", flag, 0);
      check("second done", done, 1);
      p_sda = 1'h0;
      pulse(nxt);
      cyc(1);
      check("idle", busy, 0);
      $display("test early data done");
   endtask
   // main sequence
   initial
   begin
      cyc(2);
      t_reset();
      cyc(2);
      rst = 1'h0;
      cyc(4);
      t_normal(7'h00);
      t_normal(7'h03);
      t_normal(7'h19);
      t_begin(0);
      t_begin(1);
      t_scl_first();
      t_early();
      final_report();
   end
endmodule // isc_start_gen_bench
`default_nettype wire
